// *** design/ufc_function_control.sv ***
// Function control register with set/clear access, suspend and core reset
//
// Overview of operation
// - Register read 04h-06h; write, set, clear addresses
// - Set ORs, clear masks off, write replaces
// - Suspend bit zero enters low-power mode
// - Device sets suspend bit itself on exit
// - Reset bit asserts DIR, resets core only
// - Reset done: drop DIR, clear bit, RXCMD
// - Operation mode selects transmit encoding
// - Mode 11b: no automatic SYNC or EOP
// - Termination select governs pull-up and terminations
// - Speed select enables HS, FS or LS
// - Speed 11b: LS over FS with preamble
//
// Read data is decoded from the next register value, so the read mux
// already shows an access that lands on the same clock edge.
// A wake by STP outranks a write that clears the suspend bit in the
// same cycle, so the link can never lose the exit.
// The core reset length is a parameter; pick it to suit the core.
// Bit 7 is reserved: writes to it are dropped and it reads zero.
`timescale 1ns/1ps
module ufc_function_control
   import ufc_pkg::*;
#(
   parameter int CORE_RESET_CYCLES = UFC_CORE_RESET_CYCLES // Core reset length
) (
   input wire logic sys_clk_i, // ULPI interface clock
   input wire logic rstn_i, // Asynchronous reset, active low
   input wire ufc_access_t access_i, // Register access from framer
   input wire logic [5:0] read_addr_i, // Address of a register read
   input wire logic stp_i, // Link stop signal
   input wire logic plus_line_pulldown_i, // Pull-down control, plus line
   input wire logic minus_line_pulldown_i, // Pull-down control, minus line
   output logic [7:0] read_data_o, // Read data, zero off the map
   output logic read_hit_o, // Read address maps here
   output logic [7:0] function_control_o, // Register contents
   output logic low_power_o, // Analog low-power request
   output logic core_reset_o, // Digital core reset
   output logic dir_o, // Bus direction request
   output logic rxcmd_update_o, // One-cycle RXCMD update request
   output ufc_xcvr_ctl_t xcvr_ctl_o, // Transceiver controls
   output ufc_resistors_t resistors_o // Resistor enables
);

   localparam logic [15:0] RESET_LAST = 16'(CORE_RESET_CYCLES - 1); // Final count

   // Core reset sequencer states
   typedef enum logic [1:0] {
      UFC_ST_IDLE = 2'b00,
      UFC_ST_RESET = 2'b01,
      UFC_ST_DONE = 2'b10
   } ufc_state_t;

   logic [7:0] function_control; // Register bits
   logic [7:0] next_function_control; // Register bits after this edge
   ufc_state_t state; // Sequencer state
   ufc_state_t next_state; // Sequencer state after this edge
   logic [15:0] count; // Reset cycle counter
   logic [15:0] next_count; // Counter after this edge
   logic [7:0] read_data; // Read mux result
   logic read_hit; // Read address maps here
   logic [7:0] next_read_data; // Read mux input
   logic next_read_hit; // Read decode input
   logic rxcmd_update; // Status update pulse
   logic next_rxcmd_update; // Pulse after this edge
   ufc_xcvr_ctl_t xcvr_ctl; // Transceiver controls
   ufc_xcvr_ctl_t next_xcvr_ctl; // Controls after this edge
   ufc_resistors_t resistors; // Resistor enables
   ufc_resistors_t next_resistors; // Enables after this edge
   logic low_power; // Low-power request flop
   logic next_low_power; // Low-power request after this edge
   logic reset_busy; // Core reset running, drives DIR
   logic next_reset_busy; // Core reset phase after this edge

   // Apply one access to the register value
   function automatic logic [7:0] apply_access(input logic [7:0] cur, input ufc_access_t acc);
      logic [7:0] res;
      res = cur;
      if (acc.strobe) begin
         case (acc.addr)
            UFC_ADDR_WRITE: res = acc.data;
            UFC_ADDR_SET: res = cur | acc.data;
            UFC_ADDR_CLEAR: res = cur & ~acc.data;
            default: res = cur; // Other registers
         endcase
      end
      // Reserved bit never holds a one
      return res & ~UFC_RESERVED_MASK;
   endfunction

   // Read decode across the three aliases
   function automatic logic addr_hit(input logic [5:0] a);
      return (a == UFC_ADDR_WRITE) || (a == UFC_ADDR_SET) || (a == UFC_ADDR_CLEAR);
   endfunction

   // Register update, wake-up and reset sequencing
   always_comb begin
      // Access first, then hardware updates override it
      next_function_control = apply_access(function_control, access_i);
      // Defaults: hold the sequencer, no status pulse
      next_state = state;
      next_count = count;
      next_rxcmd_update = 1'b0;
      // Wake on STP from low-power: hardware sets the bit, beating a write
      if (!function_control[UFC_BIT_LOW_POWER_N] && stp_i) begin
         next_function_control[UFC_BIT_LOW_POWER_N] = 1'b1;
      end
      case (state)
         UFC_ST_IDLE: begin
            // Reset bit newly set by the link starts the core reset
            if (function_control[UFC_BIT_CORE_RESET]) begin
               next_state = UFC_ST_RESET;
               next_count = 16'h0000;
            end
         end
         UFC_ST_RESET: begin
            // Hold bit set while the core is in reset
            next_function_control[UFC_BIT_CORE_RESET] = 1'b1;
            if (count == RESET_LAST) begin
               // Last cycle: release core, clear bit, flag RXCMD
               next_state = UFC_ST_DONE;
               next_function_control[UFC_BIT_CORE_RESET] = 1'b0;
               next_rxcmd_update = 1'b1;
            end else begin
               // Count another reset cycle
               next_count = count + 16'h0001;
            end
         end
         UFC_ST_DONE: begin
            // One cycle gap so the cleared bit is not retaken
            next_state = UFC_ST_IDLE;
         end
         default: begin
            // Unused code: back to idle
            next_state = UFC_ST_IDLE;
         end
      endcase
      // Flopped views of power state and reset phase
      next_low_power = ~next_function_control[UFC_BIT_LOW_POWER_N];
      next_reset_busy = (next_state == UFC_ST_RESET);
   end

   // Outputs decoded from the next register value
   always_comb begin
      logic [1:0] op;
      logic [1:0] spd;
      logic term;
      logic pd_both;
      // Fields of the value the register is about to hold
      op = next_function_control[UFC_BIT_OP_MODE_HI:UFC_BIT_OP_MODE_LO];
      spd = next_function_control[UFC_BIT_SPEED_HI:UFC_BIT_SPEED_LO];
      term = next_function_control[UFC_BIT_TERM];
      pd_both = plus_line_pulldown_i && minus_line_pulldown_i;
      // Read path over the three aliases
      next_read_hit = addr_hit(read_addr_i);
      next_read_data = next_read_hit ? next_function_control : 8'h00;
      // Speed select decode
      next_xcvr_ctl.hs_enable = (spd == UFC_XCVR_HS);
      next_xcvr_ctl.fs_enable = (spd == UFC_XCVR_FS) || (spd == UFC_XCVR_LS_ON_FS);
      next_xcvr_ctl.ls_enable = (spd == UFC_XCVR_LS);
      next_xcvr_ctl.ls_preamble = (spd == UFC_XCVR_LS_ON_FS);
      // Operation mode decode
      next_xcvr_ctl.non_driving = (op == UFC_OP_NONDRIVE);
      next_xcvr_ctl.no_stuff_nrzi = (op == UFC_OP_NO_STUFF);
      next_xcvr_ctl.no_sync_eop = (op == UFC_OP_NO_SYNC_EOP);
      // Pull-down controls pass straight through
      next_resistors.pulldown_plus = plus_line_pulldown_i;
      next_resistors.pulldown_minus = minus_line_pulldown_i;
      // Resistors off unless a case below turns them on
      next_resistors.fs_pullup_plus = 1'b0;
      next_resistors.fs_pullup_minus = 1'b0;
      next_resistors.hs_term = 1'b0;
      // Termination decode by speed, mode and pull-downs
      if (op != UFC_OP_NONDRIVE) begin
         // Non-driving mode keeps pull-ups and HS termination off; pull-downs still follow their inputs
         if (spd == UFC_XCVR_HS) begin
            // High speed: terminations on unless termination is selected
            next_resistors.hs_term = ~term;
         end else if (term && !pd_both) begin
            // Peripheral role: pull-up on plus (FS) or minus (LS)
            next_resistors.fs_pullup_plus = (spd != UFC_XCVR_LS);
            next_resistors.fs_pullup_minus = (spd == UFC_XCVR_LS);
         end
      end
   end

   // Register all state and outputs
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         // Reset values of every flop
         function_control <= UFC_RESET_VALUE;
         state <= UFC_ST_IDLE;
         count <= 16'h0000;
         read_data <= 8'h00;
         read_hit <= 1'b0;
         rxcmd_update <= 1'b0;
         xcvr_ctl <= '0;
         resistors <= '0;
         low_power <= 1'b0;
         reset_busy <= 1'b0;
      end else begin
         // Load the next values
         function_control <= next_function_control;
         state <= next_state;
         count <= next_count;
         read_data <= next_read_data;
         read_hit <= next_read_hit;
         rxcmd_update <= next_rxcmd_update;
         xcvr_ctl <= next_xcvr_ctl;
         resistors <= next_resistors;
         low_power <= next_low_power;
         reset_busy <= next_reset_busy;
      end
   end

   // Output flops, driven straight from registers
   assign read_data_o = read_data;
   assign read_hit_o = read_hit;
   assign function_control_o = function_control;
   assign low_power_o = low_power;
   assign core_reset_o = reset_busy;
   assign dir_o = reset_busy;
   assign rxcmd_update_o = rxcmd_update;
   assign xcvr_ctl_o = xcvr_ctl;
   assign resistors_o = resistors;

endmodule

// *** design/ufc_pkg.sv ***
// Package for the function control register block: offsets, fields, resets
package ufc_pkg;
   localparam logic [5:0] UFC_ADDR_WRITE = 6'h04; // Full write address
   localparam logic [5:0] UFC_ADDR_SET = 6'h05; // Bitwise set address
   localparam logic [5:0] UFC_ADDR_CLEAR = 6'h06; // Bitwise clear address
   localparam logic [7:0] UFC_RESET_VALUE = 8'h41; // Powered, full speed
   localparam int UFC_BIT_LOW_POWER_N = 6; // Active-low suspend bit
   localparam int UFC_BIT_CORE_RESET = 5; // Self-clearing core reset
   localparam int UFC_BIT_OP_MODE_HI = 4; // Operation mode high bit
   localparam int UFC_BIT_OP_MODE_LO = 3; // Operation mode low bit
   localparam int UFC_BIT_TERM = 2; // Termination select
   localparam int UFC_BIT_SPEED_HI = 1; // Speed select high bit
   localparam int UFC_BIT_SPEED_LO = 0; // Speed select low bit
   localparam logic [7:0] UFC_RESERVED_MASK = 8'h80; // Reserved bit 7
   localparam int UFC_CORE_RESET_CYCLES = 16; // Default core reset length

   // Operation mode codes
   typedef enum logic [1:0] {
      UFC_OP_NORMAL = 2'b00,
      UFC_OP_NONDRIVE = 2'b01,
      UFC_OP_NO_STUFF = 2'b10,
      UFC_OP_NO_SYNC_EOP = 2'b11
   } ufc_op_mode_t;

   // Transceiver speed codes
   typedef enum logic [1:0] {
      UFC_XCVR_HS = 2'b00,
      UFC_XCVR_FS = 2'b01,
      UFC_XCVR_LS = 2'b10,
      UFC_XCVR_LS_ON_FS = 2'b11
   } ufc_speed_t;

   // Register access request from the ULPI framer
   typedef struct packed {
      logic strobe;
      logic [5:0] addr;
      logic [7:0] data;
   } ufc_access_t;

   // Resistor enables for the analog front end
   typedef struct packed {
      logic fs_pullup_plus;
      logic fs_pullup_minus;
      logic hs_term;
      logic pulldown_plus;
      logic pulldown_minus;
   } ufc_resistors_t;

   // Transceiver control decoded from the register
   typedef struct packed {
      logic hs_enable;
      logic fs_enable;
      logic ls_enable;
      logic ls_preamble;
      logic non_driving;
      logic no_stuff_nrzi;
      logic no_sync_eop;
   } ufc_xcvr_ctl_t;
endpackage

// *** verification/testbench.sv ***
// Testbench for the function control register
`timescale 1ns/1ps
module testbench;
   import ufc_pkg::*;
   logic sys_clk_i, rstn_i, stp_i, pd_p, pd_m, wake, free, read_hit_o, low_power_o;
   logic core_reset_o, dir_o, rxcmd_update_o;
   logic [5:0] read_addr_i;
   logic [7:0] read_data_o, function_control_o;
   ufc_access_t access_i;
   ufc_xcvr_ctl_t xcvr_ctl_o;
   ufc_resistors_t resistors_o;
   int fails, compares, n;
   ufc_function_control #(.CORE_RESET_CYCLES(2)) u_ufc_function_control (.sys_clk_i,
      .rstn_i, .access_i, .read_addr_i, .stp_i, .plus_line_pulldown_i(pd_p),
      .minus_line_pulldown_i(pd_m), .read_data_o, .read_hit_o, .function_control_o,
      .low_power_o, .core_reset_o, .dir_o, .rxcmd_update_o, .xcvr_ctl_o, .resistors_o);
   ufc_link_model u_ufc_link_model (.sys_clk_i, .dir_i(dir_o), .wake_req_i(wake),
      .stp_o(stp_i), .bus_free_o(free));
   // Compare and count
   task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One register access once the link owns the bus
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      for (int i = 0; i < 50 && free !== 1'b1; i++) @(negedge sys_clk_i);
      @(negedge sys_clk_i);
      access_i = '{1'b1, a, d};
      @(negedge sys_clk_i);
      access_i.strobe = 1'b0;
   endtask
   // Read with hit flag
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(negedge sys_clk_i);
      read_addr_i = a;
      @(negedge sys_clk_i);
      cmp(read_data_o, exp);
      cmp({7'h00, read_hit_o}, {7'h00, a >= 6'h04 && a <= 6'h06});
   endtask
   task automatic close_out();
      $display("counts: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      #20000;
      fails++;
      close_out();
   end
   initial begin
      rstn_i = 1'b0;
      access_i = '0;
      read_addr_i = 6'h00;
      {pd_p, pd_m, wake} = 3'b000;
      repeat (6) @(negedge sys_clk_i);
      rstn_i = 1'b1;
      // Reset value at every read address, nothing beyond
      for (int a = 4; a < 8; a++) rd(a[5:0], (a < 7) ? UFC_RESET_VALUE : 8'h00);
      cmp({1'b0, xcvr_ctl_o}, 8'h20);
      $display("test reset done");
      // Full write drops bit 7 and enters low power, STP wakes
      wr(UFC_ADDR_WRITE, 8'h98);
      rd(UFC_ADDR_WRITE, 8'h18);
      cmp({7'h00, low_power_o}, 8'h01);
      wake = 1'b1;
      @(negedge sys_clk_i);
      wake = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      rd(UFC_ADDR_CLEAR, 8'h58);
      cmp({7'h00, low_power_o}, 8'h00);
      $display("test low power done");
      // Set, clear, and an unmapped write
      wr(UFC_ADDR_SET, 8'h84);
      rd(UFC_ADDR_SET, 8'h5C);
      wr(UFC_ADDR_CLEAR, 8'h1A);
      wr(6'h07, 8'hFF);
      rd(UFC_ADDR_WRITE, 8'h44);
      $display("test set clear done");
      // Every mode and speed code; mode 11b only with high speed
      for (int i = 0; i < 4; i++) begin
         wr(UFC_ADDR_WRITE, {3'b010, i[1:0], 1'b0, ~i[1:0]});
         cmp({1'b0, xcvr_ctl_o}, {1'b0, i == 3,
            i == 0 || i == 2, i == 1, i == 0, i == 1, i == 2, i == 3});
         if (i == 1) cmp({3'b000, resistors_o}, 8'h00);
      end
      cmp({3'b000, resistors_o}, 8'h04);
      wr(UFC_ADDR_WRITE, 8'h45);
      cmp({3'b000, resistors_o}, 8'h10);
      {pd_p, pd_m} = 2'b11;
      @(negedge sys_clk_i);
      cmp({3'b000, resistors_o}, 8'h03);
      {pd_p, pd_m} = 2'b00;
      wr(UFC_ADDR_WRITE, 8'h46);
      cmp({3'b000, resistors_o}, 8'h08);
      $display("test decode done");
      // Core reset keeps the register, then self-clears
      wr(UFC_ADDR_SET, 8'h20);
      for (n = 0; n < 10 && dir_o !== 1'b1; n++) @(negedge sys_clk_i);
      cmp({6'h00, dir_o, core_reset_o}, 8'h03);
      cmp(function_control_o, 8'h66);
      for (n = 0; n < 10 && dir_o !== 1'b0; n++) @(negedge sys_clk_i);
      cmp(n[7:0], 8'h02);
      cmp({7'h00, rxcmd_update_o}, 8'h01);
      rd(UFC_ADDR_WRITE, 8'h46);
      $display("test core reset done");
      close_out();
   end
endmodule

// *** verification/ufc_asserts.sv ***
// Checker for the function control register
`timescale 1ns/1ps
module ufc_asserts
   import ufc_pkg::*;
#(parameter int CORE_RESET_CYCLES = UFC_CORE_RESET_CYCLES) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire ufc_access_t access_i,
   input wire logic stp_i,
   input wire logic [7:0] function_control_o,
   input wire logic low_power_o,
   input wire logic core_reset_o,
   input wire logic dir_o,
   input wire logic rxcmd_update_o,
   input wire ufc_xcvr_ctl_t xcvr_ctl_o
);
   logic [7:0] fc, cnt, next_cnt; // Register view, DIR high count
   logic live, ok; // Decodes loaded; plain access
   assign fc = function_control_o;
   assign ok = access_i.strobe && !stp_i && !dir_o && !fc[5];
   // Count cycles with DIR high
   always_comb next_cnt = dir_o ? cnt + 8'h01 : 8'h00;
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt <= 8'h00;
         live <= 1'b0;
      end else begin
         cnt <= next_cnt;
         live <= 1'b1;
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   chk_bit7_zero: assert property (fc[7] == 1'b0)
      else $error("bit 7 set");
   chk_full_write: assert property (ok && access_i.addr == UFC_ADDR_WRITE
      |=> fc == {1'b0, $past(access_i.data[6:0])}) else $error("write wrong");
   chk_set_or: assert property (ok && access_i.addr == UFC_ADDR_SET
      |=> fc == ($past(fc | access_i.data) & 8'h7F)) else $error("set wrong");
   chk_clear_mask: assert property (ok && access_i.addr == UFC_ADDR_CLEAR
      |=> fc == $past(fc & ~access_i.data)) else $error("clear wrong");
   chk_low_power: assert property (live && !fc[6] |-> ##[0:1] low_power_o)
      else $error("no low power");
   chk_wake_exit: assert property (stp_i && !fc[6] |=> fc[6])
      else $error("no wake");
   chk_dir_core: assert property (dir_o == core_reset_o)
      else $error("dir and core reset differ");
   chk_reset_start: assert property ($rose(fc[5]) |=> dir_o)
      else $error("dir late");
   chk_reset_len: assert property ($fell(dir_o) |-> cnt == CORE_RESET_CYCLES)
      else $error("reset length");
   chk_reset_end: assert property ($fell(dir_o) |-> rxcmd_update_o && !fc[5])
      else $error("reset end");
   chk_rxcmd_pulse: assert property (rxcmd_update_o |=> !rxcmd_update_o)
      else $error("rxcmd long");
   chk_speed_map: assert property (live |-> xcvr_ctl_o.hs_enable == (fc[1:0] == 2'b00)
      && xcvr_ctl_o.ls_preamble == (fc[1:0] == 2'b11)) else $error("speed decode");
   chk_mode_map: assert property (live |-> xcvr_ctl_o.non_driving == (fc[4:3] == 2'b01)
      && xcvr_ctl_o.no_sync_eop == (fc[4:3] == 2'b11)) else $error("mode decode");
   cov_reset: cover property ($fell(dir_o));
   cov_wake: cover property (stp_i && !fc[6]);
   cov_clear: cover property (ok && access_i.addr == UFC_ADDR_CLEAR);
endmodule
bind ufc_function_control ufc_asserts #(.CORE_RESET_CYCLES(CORE_RESET_CYCLES)) u_ufc_asserts (
   .sys_clk_i, .rstn_i, .access_i, .stp_i, .function_control_o, .low_power_o,
   .core_reset_o, .dir_o, .rxcmd_update_o, .xcvr_ctl_o);

// *** verification/ufc_link_model.sv ***
// Link controller model: wake signalling and bus ownership
`timescale 1ns/1ps
module ufc_link_model (
   input wire logic sys_clk_i, // Interface clock
   input wire logic dir_i, // Direction from device
   input wire logic wake_req_i, // Bench wake request
   output logic stp_o, // Stop to device
   output logic bus_free_o // Link may use the bus
);
   initial begin
      stp_o = 1'b0;
      bus_free_o = 1'b0;
   end
   // Stop follows the wake request
   always @(posedge sys_clk_i) stp_o <= wake_req_i;
   // Bus taken back only after DIR low
   always @(posedge sys_clk_i) bus_free_o <= !dir_i;
endmodule
